// file: ptg_core_model.sv
// core side model: single byte register writes and reads on the data bus
`timescale 1ns/1ps
`default_nettype none
module ptg_core_model
   import ptg_pkg::*;
(
   input wire logic clk_in,
   output logic [ptg_pkg::ADDR_W-1:0] bus_addr_out,
   output logic [ptg_pkg::DATA_W-1:0] bus_wdata_out,
   output logic bus_wr_out,
   output logic bus_rd_out,
   input wire logic [ptg_pkg::DATA_W-1:0] bus_rdata_in
);
   initial begin
      bus_addr_out = 8'h0000;
      bus_wdata_out = 8'h0000;
      bus_wr_out = 1'b0;
      bus_rd_out = 1'b0;
   end
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk_in);
      bus_addr_out <= addr;
      bus_wdata_out <= data;
      bus_wr_out <= 1'b1;
      @(posedge clk_in);
      bus_wr_out <= 1'b0;
      // released data must not keep showing the last value
      bus_wdata_out <= ~data;
      // let the write land before the caller looks at outputs
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      @(posedge clk_in);
      bus_addr_out <= addr;
      bus_rd_out <= 1'b1;
      @(posedge clk_in);
      bus_rd_out <= 1'b0;
      @(posedge clk_in);
      #1;
      data = bus_rdata_in;
   endtask : rd
endmodule : ptg_core_model
`default_nettype wire

// file: ptg_pkg.sv
// package: register map, field layout and reset values of the pwm timer and port
package ptg_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam logic [7:0] ADDR_RELOAD = 8'h00AA;
   localparam logic [7:0] ADDR_COUNT = 8'h00AC;
   localparam logic [7:0] ADDR_CTRL = 8'h00AE;
   localparam logic [7:0] ADDR_PDATA = 8'h00B2;
   localparam logic [7:0] ADDR_PDIR = 8'h00B3;
   localparam logic [7:0] ADDR_PLVL = 8'h00B4;
   localparam int unsigned CTRL_PSC_LO = 0;
   localparam int unsigned CTRL_PSC_HI = 1;
   localparam int unsigned CTRL_IEN = 2;
   localparam int unsigned CTRL_PEND = 3;
   localparam int unsigned CTRL_RUN = 4;
   localparam int unsigned CTRL_TOG = 5;
   localparam logic [7:0] RST_RELOAD = 8'h0000;
   localparam logic [7:0] RST_COUNT = 8'h00FF;
   localparam logic [7:0] CNT_ZERO = 8'h0000;
   localparam logic [7:0] RST_CTRL = 8'h0000;
   localparam logic [5:0] RST_PORT = 6'h0000;
   localparam int unsigned PIN_N = 6;
   localparam int unsigned PIN_WAVE = 2;
   localparam int unsigned PIN_IN_ONLY = 3;
   localparam logic [1:0] IRQ_PRIORITY = 2'h0002;
   localparam logic [7:0] READ_IDLE = 8'h0000;
endpackage : ptg_pkg

// file: ptg_timer_port.sv
// pwm timer with its six pin general purpose port, on the core data bus
// Summary of operation
// - run bit four decrements counter per tick
// - prescale bits divide clock by 1,2,4,8
// - underflow 0x00 to 0xFF reloads counter
// - underflow raises interrupt, toggles output, both
// - toggle enable bit five gates output toggle
// - interrupt enable bit two requests underflow irq
// - pending state reads in control bit three
// - reset: counter 0xFF, reload 0x00
// - control bits seven, six reserved
// - waveform output shares port pin two
// - six pins; pin three input with pull-up
// - direction bit: 0 input, 1 push-pull
// - output pin drives its data bit; pin two drives waveform while toggle enabled
// - input pin data bit picks pull-up mode
// - data one pull-up, zero high impedance
// - direction and data registers read and write
// - pin level register returns actual pin levels
// - underflow interrupt has core priority two
`timescale 1ns/1ps
`default_nettype none
module ptg_timer_port
   import ptg_pkg::*;
#(
   parameter int unsigned PSC_MAX_LOG2 = 3
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [ptg_pkg::ADDR_W-1:0] bus_addr_in,
   input wire logic [ptg_pkg::DATA_W-1:0] bus_wdata_in,
   input wire logic bus_wr_in,
   input wire logic bus_rd_in,
   output logic [ptg_pkg::DATA_W-1:0] bus_rdata_out,
   input wire logic [ptg_pkg::PIN_N-1:0] pin_in,
   output logic [ptg_pkg::PIN_N-1:0] pin_out,
   output logic [ptg_pkg::PIN_N-1:0] pin_oe_out,
   output logic [ptg_pkg::PIN_N-1:0] pin_pullup_out,
   output logic underflow_irq_out,
   output logic [1:0] irq_priority_out,
   output logic waveform_out
);
   import ptg_pkg::*;

   // the prescaler and its mask decode are built for three stages only
   if (PSC_MAX_LOG2 != 3) begin : g_bad_psc
      $error("prescaler depth must be three stages");
   end

   logic [7:0] count_ff;
   logic [7:0] nxt_count;
   logic [7:0] reload_ff;
   logic [7:0] ctrl_ff;
   logic [2:0] psc_ff;
   logic toggle_ff;
   logic [5:0] pdata_ff;
   logic [5:0] pdir_ff;
   logic [5:0] sync1_ff;
   logic [5:0] sync2_ff;
   logic [7:0] rdata_ff;

   wire wr_reload = bus_wr_in && (bus_addr_in == ADDR_RELOAD);
   wire wr_count = bus_wr_in && (bus_addr_in == ADDR_COUNT);
   wire wr_ctrl = bus_wr_in && (bus_addr_in == ADDR_CTRL);
   wire wr_pdata = bus_wr_in && (bus_addr_in == ADDR_PDATA);
   wire wr_pdir = bus_wr_in && (bus_addr_in == ADDR_PDIR);

   wire run = ctrl_ff[CTRL_RUN];
   wire tog_en = ctrl_ff[CTRL_TOG];
   wire [1:0] psc_sel = ctrl_ff[CTRL_PSC_HI:CTRL_PSC_LO];

   // tick when low psc_sel bits of prescaler are all ones; sel 0 ticks every clock
   wire [2:0] psc_mask = (psc_sel == 2'h0000) ? 3'h0000 :
                         (psc_sel == 2'h0001) ? 3'h0001 :
                         (psc_sel == 2'h0002) ? 3'h0003 : 3'h0007;
   wire tick = run && ((psc_ff & psc_mask) == psc_mask);
   wire underflow = tick && (count_ff == CNT_ZERO);

   // a bus write to the counter wins over counting in that cycle
   always_comb begin
      nxt_count = count_ff;
      if (wr_count) begin
         nxt_count = bus_wdata_in;
      end else if (underflow) begin
         nxt_count = reload_ff;
      end else if (tick) begin
         nxt_count = count_ff - 8'h0001;
      end
   end

   // prescaler restarts whenever the timer is stopped, so the first period is whole
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         psc_ff <= 3'h0000;
      end else if (!run) begin
         psc_ff <= 3'h0000;
      end else begin
         psc_ff <= psc_ff + 3'h0001;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         count_ff <= RST_COUNT;
         reload_ff <= RST_RELOAD;
      end else begin
         count_ff <= nxt_count;
         if (wr_reload) begin
            reload_ff <= bus_wdata_in;
         end
      end
   end

   // pending: set wins over a software clear in the same cycle; writing 1 keeps it
   wire nxt_pend = underflow | (ctrl_ff[CTRL_PEND] &
                   ~(wr_ctrl & ~bus_wdata_in[CTRL_PEND]));

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         ctrl_ff <= RST_CTRL;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff[CTRL_TOG] <= bus_wdata_in[CTRL_TOG];
            ctrl_ff[CTRL_RUN] <= bus_wdata_in[CTRL_RUN];
            ctrl_ff[CTRL_IEN] <= bus_wdata_in[CTRL_IEN];
            ctrl_ff[CTRL_PSC_HI:CTRL_PSC_LO] <= bus_wdata_in[CTRL_PSC_HI:CTRL_PSC_LO];
         end
         ctrl_ff[CTRL_PEND] <= nxt_pend;
         ctrl_ff[7:6] <= 2'h0000;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         toggle_ff <= 1'b0;
      end else if (underflow && tog_en) begin
         toggle_ff <= ~toggle_ff;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         pdata_ff <= RST_PORT;
         pdir_ff <= RST_PORT;
      end else begin
         if (wr_pdata) begin
            pdata_ff <= bus_wdata_in[PIN_N-1:0];
         end
         if (wr_pdir) begin
            pdir_ff <= bus_wdata_in[PIN_N-1:0];
         end
      end
   end

   // pins are asynchronous to the core clock
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         sync1_ff <= RST_PORT;
         sync2_ff <= RST_PORT;
      end else begin
         sync1_ff <= pin_in;
         sync2_ff <= sync1_ff;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < PIN_N; gi++) begin : g_pin
         if (gi == PIN_IN_ONLY) begin : g_in_only
            assign pin_oe_out[gi] = 1'b0;
            assign pin_out[gi] = 1'b0;
            assign pin_pullup_out[gi] = 1'b1;
         end else if (gi == PIN_WAVE) begin : g_wave
            assign pin_oe_out[gi] = pdir_ff[gi];
            assign pin_out[gi] = tog_en ? toggle_ff : pdata_ff[gi];
            assign pin_pullup_out[gi] = ~pdir_ff[gi] & pdata_ff[gi];
         end else begin : g_gp
            assign pin_oe_out[gi] = pdir_ff[gi];
            assign pin_out[gi] = pdata_ff[gi];
            assign pin_pullup_out[gi] = ~pdir_ff[gi] & pdata_ff[gi];
         end
      end
   endgenerate

   // read data registered: answer appears the edge after the read strobe
   wire [7:0] rd_mux = (bus_addr_in == ADDR_RELOAD) ? reload_ff :
                       (bus_addr_in == ADDR_COUNT) ? count_ff :
                       (bus_addr_in == ADDR_CTRL) ? ctrl_ff :
                       (bus_addr_in == ADDR_PDATA) ? {2'h0000, pdata_ff} :
                       (bus_addr_in == ADDR_PDIR) ? {2'h0000, pdir_ff} :
                       (bus_addr_in == ADDR_PLVL) ? {2'h0000, sync2_ff} :
                       READ_IDLE;

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         rdata_ff <= READ_IDLE;
      end else if (bus_rd_in) begin
         rdata_ff <= rd_mux;
      end
   end

   assign bus_rdata_out = rdata_ff;
   assign underflow_irq_out = ctrl_ff[CTRL_PEND] & ctrl_ff[CTRL_IEN];
   assign irq_priority_out = IRQ_PRIORITY;
   assign waveform_out = toggle_ff;

   property p_run_hold;
      @(posedge clk_in) disable iff (reset_in)
      (!run && !wr_count) |=> (count_ff == $past(count_ff));
   endproperty
   a_run_hold: assert property (p_run_hold) else $error("counter moved while stopped");

   property p_div8;
      @(posedge clk_in) disable iff (reset_in)
      (tick && psc_sel == 2'h0003 && run) |=> (!tick || psc_sel != 2'h0003)[*7];
   endproperty
   a_div8: assert property (p_div8) else $error("divide by 8 ticked early");

   property p_reload;
      @(posedge clk_in) disable iff (reset_in)
      (underflow && !wr_count && !wr_reload) |=> (count_ff == $past(reload_ff));
   endproperty
   a_reload: assert property (p_reload) else $error("no reload on underflow");

   property p_toggle;
      @(posedge clk_in) disable iff (reset_in)
      (underflow && tog_en) |=> (toggle_ff != $past(toggle_ff));
   endproperty
   a_toggle: assert property (p_toggle) else $error("output did not toggle");

   property p_notog;
      @(posedge clk_in) disable iff (reset_in)
      !(underflow && tog_en) |=> $stable(toggle_ff);
   endproperty
   a_notog: assert property (p_notog) else $error("output toggled without cause");

   property p_irq;
      @(posedge clk_in) disable iff (reset_in)
      (underflow && ctrl_ff[CTRL_IEN] && !wr_ctrl) |=> underflow_irq_out;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing after underflow");

   property p_pend_set;
      @(posedge clk_in) disable iff (reset_in)
      underflow |=> ctrl_ff[CTRL_PEND];
   endproperty
   a_pend_set: assert property (p_pend_set) else $error("pending not set");

   property p_pin3;
      @(posedge clk_in) disable iff (reset_in)
      !pin_oe_out[PIN_IN_ONLY] && pin_pullup_out[PIN_IN_ONLY];
   endproperty
   a_pin3: assert property (p_pin3) else $error("pin three not pulled-up input");

   property p_rsv;
      @(posedge clk_in) disable iff (reset_in)
      wr_ctrl |=> (ctrl_ff[7:6] == 2'h0000);
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved control bits set");

   property p_count_dec;
      @(posedge clk_in) disable iff (reset_in)
      (tick && count_ff != CNT_ZERO && !wr_count) |=> (count_ff == $past(count_ff) - 8'h0001);
   endproperty
   a_count_dec: assert property (p_count_dec) else $error("counter did not step down");

   property p_div1;
      @(posedge clk_in) disable iff (reset_in)
      (run && psc_sel == 2'h0000) |-> tick;
   endproperty
   a_div1: assert property (p_div1) else $error("divide by 1 missed a tick");

   property p_div2;
      @(posedge clk_in) disable iff (reset_in)
      (tick && psc_sel == 2'h0001) |=> (!tick || psc_sel != 2'h0001);
   endproperty
   a_div2: assert property (p_div2) else $error("divide by 2 ticked early");

   // a clear that meets an underflow loses, so only plain clears are checked here
   property p_pend_clr;
      @(posedge clk_in) disable iff (reset_in)
      (wr_ctrl && !bus_wdata_in[CTRL_PEND] && !underflow) |=> !ctrl_ff[CTRL_PEND];
   endproperty
   a_pend_clr: assert property (p_pend_clr) else $error("pending not cleared");

   property p_pend_keep;
      @(posedge clk_in) disable iff (reset_in)
      (ctrl_ff[CTRL_PEND] && !(wr_ctrl && !bus_wdata_in[CTRL_PEND])) |=> ctrl_ff[CTRL_PEND];
   endproperty
   a_pend_keep: assert property (p_pend_keep) else $error("pending lost");

   property p_irq_gate;
      @(posedge clk_in) disable iff (reset_in)
      !ctrl_ff[CTRL_IEN] |-> !underflow_irq_out;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");

   property p_pin_drive;
      @(posedge clk_in) disable iff (reset_in)
      (pin_oe_out[PIN_WAVE] && !tog_en) |-> (pin_out[PIN_WAVE] == pdata_ff[PIN_WAVE]);
   endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("output pin ignores data");

   property p_rdata_hold;
      @(posedge clk_in) disable iff (reset_in)
      !bus_rd_in |=> $stable(bus_rdata_out);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule : ptg_timer_port
`default_nettype wire

// file: ptg_timer_port_test.sv
// self-checking bench for the pwm timer and port block
`timescale 1ns/1ps
`default_nettype none
module ptg_timer_port_test;
   import ptg_pkg::*;
   logic clk_in, reset_in, wr, rd, irq, wave;
   logic [7:0] addr, wdata, rdata;
   logic [5:0] pin_lvl, pout, poe, pup, ext_drv;
   logic [1:0] prio;
   int miscompares = 0;
   int n_tests = 0;
   int cyc = 0;
   int n;
   logic w;
   // output pins show their drive, inputs see the outside source
   assign pin_lvl = (poe & pout) | (~poe & ext_drv);
   ptg_core_model u_ptg_core_model (.clk_in(clk_in), .bus_addr_out(addr),
      .bus_wdata_out(wdata), .bus_wr_out(wr), .bus_rd_out(rd), .bus_rdata_in(rdata));
   ptg_timer_port u_ptg_timer_port (.clk_in(clk_in), .reset_in(reset_in),
      .bus_addr_in(addr), .bus_wdata_in(wdata), .bus_wr_in(wr), .bus_rd_in(rd),
      .bus_rdata_out(rdata), .pin_in(pin_lvl), .pin_out(pout), .pin_oe_out(poe),
      .pin_pullup_out(pup), .underflow_irq_out(irq), .irq_priority_out(prio),
      .waveform_out(wave));
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   task automatic finish_test;
      if (miscompares == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test
   // hang guard well above the roughly 650 cycles of the run
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 6000) begin
         miscompares++;
         finish_test();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         miscompares++;
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_ptg_core_model.rd(a, d);
      chk(d, exp);
   endtask : rchk
   task automatic wchg(output int k);
      logic v;
      v = wave;
      k = 0;
      while (wave === v && k < 300) begin
         @(posedge clk_in);
         #1;
         k++;
      end
   endtask : wchg
   initial begin
      reset_in = 1'b1;
      ext_drv = 6'h002A;
      repeat (3) @(posedge clk_in);
      reset_in <= 1'b0;
      rchk(ADDR_COUNT, 8'h00FF);
      rchk(ADDR_RELOAD, 8'h0000);
      rchk(ADDR_CTRL, 8'h0000);
      chk({2'h0, pup}, 8'h0008);
      chk({6'h0000, prio}, 8'h0002);
      u_ptg_core_model.wr(8'h00AB, 8'h0055);
      rchk(8'h00AB, 8'h0000);
      u_ptg_core_model.wr(ADDR_PDIR, 8'h00FF);
      u_ptg_core_model.wr(ADDR_PDATA, 8'h0015);
      rchk(ADDR_PDIR, 8'h003F);
      rchk(ADDR_PDATA, 8'h0015);
      chk({2'h0, poe}, 8'h0037);
      chk({2'h0, pout & poe}, 8'h0015);
      chk({2'h0, pup}, 8'h0008);
      rchk(ADDR_PLVL, 8'h001D);
      u_ptg_core_model.wr(ADDR_PDIR, 8'h0000);
      chk({2'h0, poe}, 8'h0000);
      chk({2'h0, pup}, 8'h001D);
      repeat (2) @(posedge clk_in);
      rchk(ADDR_PLVL, 8'h002A);
      u_ptg_core_model.wr(ADDR_PDIR, 8'h0004);
      u_ptg_core_model.wr(ADDR_RELOAD, 8'h0003);
      for (int p = 0; p < 4; p++) begin
         u_ptg_core_model.wr(ADDR_CTRL, 8'h0030 | 8'(p));
         wchg(n);
         wchg(n);
         chk(8'(n), 8'(4 << p));
         chk({7'h0000, pout[2]}, {7'h0000, wave});
      end
      u_ptg_core_model.wr(ADDR_CTRL, 8'h0014);
      w = wave;
      repeat (40) @(posedge clk_in);
      chk({7'h0000, wave}, {7'h0000, w});
      chk({7'h0000, irq}, 8'h0001);
      u_ptg_core_model.wr(ADDR_CTRL, 8'h00CC);
      rchk(ADDR_CTRL, 8'h000C);
      u_ptg_core_model.wr(ADDR_CTRL, 8'h0004);
      rchk(ADDR_CTRL, 8'h0004);
      chk({7'h0000, irq}, 8'h0000);
      u_ptg_core_model.wr(ADDR_COUNT, 8'h0080);
      repeat (20) @(posedge clk_in);
      rchk(ADDR_COUNT, 8'h0080);
      u_ptg_core_model.wr(ADDR_CTRL, 8'h0010);
      rchk(ADDR_CTRL, 8'h0010);
      repeat (150) @(posedge clk_in);
      rchk(ADDR_CTRL, 8'h0018);
      chk({7'h0000, irq}, 8'h0000);
      finish_test();
   end
endmodule : ptg_timer_port_test
`default_nettype wire
